/* File: sf_front_regs.svh */
// Opcodes, timing counts and address masks of the serial flash command front end
`ifndef SF_FRONT_REGS_SVH
`define SF_FRONT_REGS_SVH

// ------------------------------------------------------------
// Short address opcode set (three address bytes; the chip erase opcodes take none)
// ------------------------------------------------------------
`define OPC_READ_SHORT 8'h03
`define OPC_FAST_SHORT 8'h0b
`define OPC_PROG_SHORT 8'h02
`define OPC_SECT_SHORT 8'h20
`define OPC_BLOCK_SHORT 8'hd8
`define OPC_CHIP_A 8'h60
`define OPC_CHIP_B 8'hc7

// ------------------------------------------------------------
// Long address opcode set (four address bytes)
// ------------------------------------------------------------
`define OPC_READ_LONG 8'h13
`define OPC_FAST_LONG 8'h0c
`define OPC_PROG_LONG 8'h12
`define OPC_SECT_LONG 8'h21
`define OPC_BLOCK_LONG 8'hdc

// ------------------------------------------------------------
// Setting opcodes
// ------------------------------------------------------------
`define OPC_WR_ENABLE 8'h06
`define OPC_WR_DISABLE 8'h04
`define OPC_SUSPEND 8'hb0
`define OPC_RESUME 8'h30
`define OPC_DEEP_SLEEP 8'hb9
`define OPC_BURST_LEN 8'hc0
`define OPC_SECURE_ENTER 8'hb1
`define OPC_SECURE_EXIT 8'hc1

// ------------------------------------------------------------
// Counts, positions and reset values
// ------------------------------------------------------------
`define ADDR_BYTES_SHORT 3'd3
`define ADDR_BYTES_LONG 3'd4
`define DUMMY_CYCLES 8
`define PAGE_BYTES 9'd256
`define SECTOR_MASK 32'h0000_0fff
`define BLOCK_MASK 32'h0000_ffff
`define BURST_LEN_RESET 8'h00

`endif

/* File: sf_front_pkg.sv */
// Types shared by the serial flash command front end
package sf_front_pkg;

    // Phase of the frame decoder on the serial clock
    typedef enum logic [2:0] {
        PH_OPCODE,
        PH_ADDR,
        PH_DUMMY,
        PH_DATA_IN,
        PH_DATA_OUT,
        PH_DONE,
        PH_IGNORE
    } phase_t;

    // Array operation handed to the array engine
    typedef enum logic [2:0] {
        OP_NONE,
        OP_PROGRAM,
        OP_SECTOR_ERASE,
        OP_BLOCK_ERASE,
        OP_CHIP_ERASE
    } op_kind_t;

    typedef struct packed {
        logic valid;
        op_kind_t kind;
        logic otp;
        logic [31:0] addr;
        logic [8:0] count;
    } op_req_t;

    typedef struct packed {
        logic write_latch_flag;
        logic busy;
        logic suspended;
        logic deep_sleep;
        logic secure;
        logic [7:0] burst_len;
    } status_t;

    // Flags seen by the serial clock side
    typedef struct packed {
        logic busy;
        logic suspended;
        logic deep_sleep;
        logic secure;
        logic dtr;
    } link_flags_t;

    typedef struct packed {
        phase_t phase;
        logic [7:0] sr;
        logic [7:0] opc;
        logic [7:0] arg;
        logic [2:0] bits;
        logic [2:0] abytes;
        logic [2:0] opos;
        logic [4:0] dummy;
        logic [31:0] addr;
        logic [8:0] dcnt;
        logic [7:0] wptr;
        logic wr;
        logic done;
        logic tog;
    } link_state_t;

    typedef struct packed {
        status_t st;
        op_req_t op;
        logic seen;
        logic cs_prev;
        logic [7:0] pg_byte;
    } ctl_state_t;

endpackage

/* File: sf_sync2.sv */
// Two flip-flop level synchroniser, any width
`timescale 1ns/100ps
module sf_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // Stage 0 feeds stage 1 only
    logic [1:0][W-1:0] sync_q;

    // ------------------------------------------------------------
    // Capture chain
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_q <= {RESET_VAL, RESET_VAL};
        end else begin
            sync_q <= {sync_q[0], d_i};
        end
    end

    assign q_o = sync_q[1];
endmodule

/* File: sf_front.sv */
// Serial flash single-line command front end: framing, decode, command commit
// Behaviour
// - Invalid command: standby until next select fall
// - Standby keeps serial output released
// - Valid command serviced until select rises
// - Single rate: sample rising, launch falling
// - Double rate: sample and launch both edges
// - Busy array: array commands ignored except reads while suspended, operation continues
// - Short set opcodes, three address bytes
// - Long set opcodes, four address bytes
// - Reads stream bytes while select low
// - Page program carries 1 to 256 bytes
// - Erase addressed sector or 64KB block
// - Enable sets, disable clears write latch
// - Suspend and resume program or erase
// - Deep sleep opcode enters deep sleep
// - Burst length command takes one byte
// - Enter and leave secure area mode
// - Program, erase and burst length need write latch set first
// - Deep sleep rejects all but release
// - Secure mode refuses normal array access
`timescale 1ns/100ps
`include "sf_front_regs.svh"
module sf_front #(
    parameter int DUMMY_CYCLES = `DUMMY_CYCLES,
    parameter logic [7:0] WAKE_OPC = 8'hfe
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    input wire logic dtr_i,
    output logic [31:0] rd_addr_o,
    output logic rd_otp_o,
    output logic rd_active_o,
    input wire logic [7:0] rd_byte_i,
    output sf_front_pkg::op_req_t op_o,
    input wire logic op_done_i,
    input wire logic [7:0] pg_idx_i,
    output logic [7:0] pg_byte_o,
    output sf_front_pkg::status_t status_o
);
    import sf_front_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DUMMY_CYCLES < 1 || DUMMY_CYCLES > 15) begin : g_bad_dummy
        $error("DUMMY_CYCLES must lie in 1..15");
    end

    localparam logic [4:0] DUMMY_STR = 5'(DUMMY_CYCLES);
    localparam logic [4:0] DUMMY_DTR = 5'(2 * DUMMY_CYCLES);
    localparam ctl_state_t CTL_RESET = '{
        st: '{burst_len: `BURST_LEN_RESET, default: 1'b0},
        op: '0, seen: 1'b0, cs_prev: 1'b1, pg_byte: 8'h00};

    link_state_t link_q, link_d; // Serial clock side decoder
    ctl_state_t ctl_q, ctl_d; // System clock side command state
    link_flags_t lf; // Flags synchronised to serial clock
    logic [2:0] lk_s; // {select, complete, frame toggle} on clk
    logic fresh_q; // No serial edge yet in this frame
    logic neg_q; // Bit sampled on falling edge
    logic so_n_q; // Bit launched on falling edge
    logic so_p_q; // Bit launched on rising edge
    logic [7:0] pg_mem [0:255]; // Page program buffer

    // ------------------------------------------------------------
    // Opcode classes
    // ------------------------------------------------------------
    function automatic logic is_read(input logic [7:0] o);
        is_read = o == `OPC_READ_SHORT || o == `OPC_FAST_SHORT
            || o == `OPC_READ_LONG || o == `OPC_FAST_LONG;
    endfunction

    function automatic logic is_fast(input logic [7:0] o);
        is_fast = o == `OPC_FAST_SHORT || o == `OPC_FAST_LONG;
    endfunction

    function automatic logic is_prog(input logic [7:0] o);
        is_prog = o == `OPC_PROG_SHORT || o == `OPC_PROG_LONG;
    endfunction

    function automatic op_kind_t kind_of(input logic [7:0] o);
        case (o)
            `OPC_PROG_SHORT, `OPC_PROG_LONG: kind_of = OP_PROGRAM;
            `OPC_SECT_SHORT, `OPC_SECT_LONG: kind_of = OP_SECTOR_ERASE;
            `OPC_BLOCK_SHORT, `OPC_BLOCK_LONG: kind_of = OP_BLOCK_ERASE;
            `OPC_CHIP_A, `OPC_CHIP_B: kind_of = OP_CHIP_ERASE;
            default: kind_of = OP_NONE;
        endcase
    endfunction

    function automatic logic is_erase(input logic [7:0] o);
        is_erase = kind_of(o) inside {OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE};
    endfunction

    // ------------------------------------------------------------
    // Opcode byte decode with refusal gates
    // ------------------------------------------------------------
    function automatic link_state_t decode_opc(input link_state_t s, input link_flags_t f);
        link_state_t n;
        logic [7:0] o;
        logic array_cmd;
        n = s;
        o = s.sr;
        n.opc = o;
        array_cmd = is_read(o) || is_prog(o) || is_erase(o);
        case (o)
            // Short set
            `OPC_READ_SHORT, `OPC_FAST_SHORT, `OPC_PROG_SHORT,
            `OPC_SECT_SHORT, `OPC_BLOCK_SHORT: begin
                n.phase = PH_ADDR;
                n.abytes = `ADDR_BYTES_SHORT;
            end
            // Long set
            `OPC_READ_LONG, `OPC_FAST_LONG, `OPC_PROG_LONG,
            `OPC_SECT_LONG, `OPC_BLOCK_LONG: begin
                n.phase = PH_ADDR;
                n.abytes = `ADDR_BYTES_LONG;
            end
            // Single-byte commands
            `OPC_CHIP_A, `OPC_CHIP_B, `OPC_WR_ENABLE, `OPC_WR_DISABLE,
            `OPC_SUSPEND, `OPC_RESUME, `OPC_DEEP_SLEEP,
            `OPC_SECURE_ENTER, `OPC_SECURE_EXIT, WAKE_OPC: begin
                n.phase = PH_DONE;
                n.done = 1'b1;
            end
            // One data byte follows
            `OPC_BURST_LEN: begin
                n.phase = PH_DATA_IN;
            end
            // Unknown opcode
            default: begin
                n.phase = PH_IGNORE;
            end
        endcase
        // Deep sleep only answers its release
        if (f.deep_sleep && o != WAKE_OPC) begin
            n.phase = PH_IGNORE;
        end
        // Busy array: reads pass only while suspended
        if (f.busy && array_cmd && !(f.suspended && is_read(o))) begin
            n.phase = PH_IGNORE;
        end
        // Secure area has no erase of the normal array
        if (f.secure && is_erase(o)) begin
            n.phase = PH_IGNORE;
        end
        if (n.phase == PH_IGNORE) begin
            n.done = 1'b0;
        end
        decode_opc = n;
    endfunction

    // ------------------------------------------------------------
    // One received bit
    // ------------------------------------------------------------
    function automatic link_state_t step_bit(input link_state_t s, input logic b,
                                             input link_flags_t f);
        link_state_t n;
        logic [7:0] by;
        n = s;
        by = {s.sr[6:0], b};
        case (s.phase)
            // Byte-shaped phases
            PH_OPCODE, PH_ADDR, PH_DATA_IN: begin
                n.sr = by;
                n.bits = s.bits + 3'd1;
                if (s.bits == 3'd7) begin
                    if (s.phase == PH_OPCODE) begin
                        n = decode_opc(n, f);
                    end else if (s.phase == PH_ADDR) begin
                        n.addr = {s.addr[23:0], by};
                        n.abytes = s.abytes - 3'd1;
                        if (s.abytes == 3'd1) begin
                            n.wptr = by;
                            if (is_fast(s.opc)) begin
                                n.phase = PH_DUMMY;
                                n.dummy = f.dtr ? DUMMY_DTR : DUMMY_STR;
                            end else if (is_read(s.opc)) begin
                                n.phase = PH_DATA_OUT;
                            end else if (is_prog(s.opc)) begin
                                n.phase = PH_DATA_IN;
                            end else begin
                                n.phase = PH_DONE;
                                n.done = 1'b1;
                            end
                        end
                    end else begin
                        n.arg = by;
                        n.done = 1'b1;
                        if (is_prog(s.opc)) begin
                            n.wr = 1'b1;
                            n.wptr = s.wptr + 8'd1;
                            if (s.dcnt != `PAGE_BYTES) begin
                                n.dcnt = s.dcnt + 9'd1;
                            end
                        end else begin
                            n.phase = PH_DONE;
                        end
                    end
                end
            end
            // Dummy clocks before read data
            PH_DUMMY: begin
                n.dummy = s.dummy - 5'd1;
                if (s.dummy == 5'd1) begin
                    n.phase = PH_DATA_OUT;
                end
            end
            // Output, finished or ignored frames take no input
            default: begin
                n.sr = s.sr;
            end
        endcase
        step_bit = n;
    endfunction

    // ------------------------------------------------------------
    // Frame start marker, set by select high
    // ------------------------------------------------------------
    always_ff @(posedge sck_i or posedge cs_n_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fresh_q <= 1'b1;
        end else if (cs_n_i) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Serial clock side decoder, next state
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] pos_sum;
        pos_sum = 4'h0;
        link_d = link_q;
        link_d.wr = 1'b0;
        if (fresh_q) begin
            // New frame clears all frame state except the frame toggle, which flips
            link_d = '0;
            link_d.phase = PH_OPCODE;
            link_d.tog = ~link_q.tog;
        end else if (link_q.phase == PH_DATA_OUT) begin
            // Output position, two slots per clock in double rate
            pos_sum = {1'b0, link_q.opos} + (lf.dtr ? 4'd2 : 4'd1);
            link_d.opos = pos_sum[2:0];
            if (pos_sum[3]) begin
                link_d.addr = link_q.addr + 32'd1;
            end
        end
        if (lf.dtr && !fresh_q) begin
            link_d = step_bit(link_d, neg_q, lf);
        end
        link_d = step_bit(link_d, si_i, lf);
    end

    // ------------------------------------------------------------
    // Serial clock side registers and page buffer write
    // ------------------------------------------------------------
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link_q <= '0;
            so_p_q <= 1'b0;
        end else begin
            link_q <= link_d;
            so_p_q <= rd_byte_i[3'(3'd6 - link_q.opos)];
        end
    end

    // Buffer has no reset; only written bytes are ever used
    always_ff @(posedge sck_i) begin
        if (link_d.wr) begin
            pg_mem[link_d.wptr - 8'd1] <= link_d.arg;
        end
    end

    // ------------------------------------------------------------
    // Falling edge sampling and launch
    // ------------------------------------------------------------
    always_ff @(negedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            neg_q <= 1'b0;
            so_n_q <= 1'b0;
        end else begin
            neg_q <= si_i;
            so_n_q <= rd_byte_i[~link_q.opos];
        end
    end

    // Double rate shows the rising-edge bit while the clock is high
    assign so_o = (lf.dtr && sck_i) ? so_p_q : so_n_q;
    // Phase left over from the last frame must not drive before the first edge
    assign so_oe_o = !cs_n_i && !fresh_q && link_q.phase == PH_DATA_OUT;
    assign rd_addr_o = link_q.addr;
    assign rd_active_o = link_q.phase == PH_DATA_OUT;
    assign rd_otp_o = lf.secure;

    // ------------------------------------------------------------
    // Domain crossings
    // ------------------------------------------------------------
    sf_sync2 #(.W(5), .RESET_VAL(5'h00)) u_flags_sync (
        .clk_i(sck_i),
        .rstn_i(rstn_i),
        .d_i({ctl_q.st.busy, ctl_q.st.suspended, ctl_q.st.deep_sleep,
              ctl_q.st.secure, dtr_i}),
        .q_o(lf)
    );

    sf_sync2 #(.W(3), .RESET_VAL(3'b100)) u_link_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i({cs_n_i, link_q.done, link_q.tog}),
        .q_o(lk_s)
    );

    // ------------------------------------------------------------
    // Command commit at the end of each frame
    // ------------------------------------------------------------
    always_comb begin
        logic commit;
        op_kind_t kind;
        logic [31:0] mask;
        ctl_d = ctl_q;
        ctl_d.op.valid = 1'b0;
        ctl_d.cs_prev = lk_s[2];
        ctl_d.pg_byte = pg_mem[pg_idx_i];
        kind = kind_of(link_q.opc);
        mask = (kind == OP_SECTOR_ERASE) ? `SECTOR_MASK
             : (kind == OP_BLOCK_ERASE) ? `BLOCK_MASK : 32'h0000_0000;
        // Frame fields stay still once select is high
        commit = lk_s[2] && !ctl_q.cs_prev && lk_s[1] && lk_s[0] != ctl_q.seen;
        // Every select rise marks its frame seen, complete or not
        if (lk_s[2] && !ctl_q.cs_prev) begin
            ctl_d.seen = lk_s[0];
        end
        // Array engine finished
        if (op_done_i) begin
            ctl_d.st.busy = 1'b0;
            ctl_d.st.suspended = 1'b0;
        end
        if (commit) begin
            case (link_q.opc)
                `OPC_WR_ENABLE: ctl_d.st.write_latch_flag = 1'b1;
                `OPC_WR_DISABLE: ctl_d.st.write_latch_flag = 1'b0;
                `OPC_SUSPEND: ctl_d.st.suspended = ctl_d.st.busy;
                `OPC_RESUME: ctl_d.st.suspended = 1'b0;
                `OPC_DEEP_SLEEP: ctl_d.st.deep_sleep = 1'b1;
                WAKE_OPC: ctl_d.st.deep_sleep = 1'b0;
                `OPC_SECURE_ENTER: ctl_d.st.secure = 1'b1;
                `OPC_SECURE_EXIT: ctl_d.st.secure = 1'b0;
                // Setting change needs the write latch
                `OPC_BURST_LEN: begin
                    if (ctl_q.st.write_latch_flag) begin
                        ctl_d.st.burst_len = link_q.arg;
                        ctl_d.st.write_latch_flag = 1'b0;
                    end
                end
                // Program and erase need the write latch
                default: begin
                    if (kind != OP_NONE && ctl_q.st.write_latch_flag) begin
                        ctl_d.op.valid = 1'b1;
                        ctl_d.op.kind = kind;
                        ctl_d.op.otp = ctl_q.st.secure;
                        ctl_d.op.addr = link_q.addr & ~mask;
                        ctl_d.op.count = link_q.dcnt;
                        ctl_d.st.busy = 1'b1;
                        ctl_d.st.write_latch_flag = 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // System clock registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctl_q <= CTL_RESET;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign op_o = ctl_q.op;
    assign status_o = ctl_q.st;
    assign pg_byte_o = ctl_q.pg_byte;
endmodule

/* File: sf_front_props.sv */
// Checker of commit, status and output enable of the command front end
`timescale 1ns/100ps
module sf_front_props (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cs_n_i,
    input wire logic so_oe_o,
    input wire logic op_done_i,
    input wire sf_front_pkg::op_req_t op_o,
    input wire sf_front_pkg::status_t status_o
);
    import sf_front_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_oe_sel; so_oe_o |-> !cs_n_i; endproperty
    a_oe_sel: assert property (p_oe_sel)
        else $error("output enabled while deselected");
    property p_cs; op_o.valid |-> cs_n_i; endproperty
    a_cs: assert property (p_cs)
        else $error("commit while frame open");
    property p_busy; op_o.valid |=> status_o.busy; endproperty
    a_busy: assert property (p_busy)
        else $error("busy not set by commit");
    property p_wel;
        $rose(op_o.valid) |-> $past(status_o.write_latch_flag) && !status_o.write_latch_flag;
    endproperty
    a_wel: assert property (p_wel)
        else $error("commit without write latch");
    property p_sect; op_o.valid && op_o.kind == OP_SECTOR_ERASE |-> op_o.addr[11:0] == 12'h000;
    endproperty
    a_sect: assert property (p_sect)
        else $error("sector address not aligned");
    property p_blk; op_o.valid && op_o.kind == OP_BLOCK_ERASE |-> op_o.addr[15:0] == 16'h0000;
    endproperty
    a_blk: assert property (p_blk)
        else $error("block address not aligned");
    property p_cnt; op_o.valid && op_o.kind == OP_PROGRAM |-> op_o.count inside {[9'h001:9'h100]};
    endproperty
    a_cnt: assert property (p_cnt)
        else $error("program count out of range");
    property p_done; op_done_i |=> !status_o.suspended && (!status_o.busy || op_o.valid);
    endproperty
    a_done: assert property (p_done)
        else $error("completion did not clear busy");
    property p_deep; status_o.deep_sleep |=> !op_o.valid; endproperty
    a_deep: assert property (p_deep)
        else $error("commit during deep sleep");
    property p_otp; op_o.valid && op_o.otp |-> op_o.kind == OP_PROGRAM; endproperty
    a_otp: assert property (p_otp)
        else $error("array erase in secure mode");
    // Main scenarios reached
    c_prog: cover property (op_o.valid && op_o.kind == OP_PROGRAM);
    c_chip: cover property (op_o.valid && op_o.kind == OP_CHIP_ERASE);
    c_deep: cover property ($rose(status_o.deep_sleep));
endmodule
bind sf_front sf_front_props u_props (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
    .so_oe_o(so_oe_o), .op_done_i(op_done_i), .op_o(op_o), .status_o(status_o));

/* File: sf_host.sv */
// Host serial controller model: select, clock and data in, single rate
`timescale 1ns/100ps
module sf_host (
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    // Released line shows the inverse, so a held value never passes
    wire so_w = so_oe_i ? so_i : ~so_i;
    // Clock stands still between frames
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    task automatic start();
        #7.3 cs_n_o = 1'b0;
        #62.5;
    endtask
    // One byte each way, most significant bit first
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            si_o = d[i];
            #62.5 sck_o = 1'b1;
            q[i] = so_w;
            #62.5 sck_o = 1'b0;
        end
    endtask
    // Close frame and keep select high long enough
    task automatic stop();
        #31.2 cs_n_o = 1'b1;
        si_o = ~si_o;
        #300;
    endtask
endmodule

/* File: tb.sv */
// Testbench of the serial flash command front end
`timescale 1ns/100ps
module tb;
    import sf_front_pkg::*;
    logic clk_i, rstn_i, dtr_i, op_done_i, sck_i, cs_n_i, si_i, so_o, so_oe_o;
    logic rd_otp_o, rd_active_o;
    logic [31:0] rd_addr_o;
    logic [7:0] rd_byte_i, pg_idx_i, pg_byte_o;
    op_req_t op_o, last_op;
    status_t status_o;
    int n_mismatch = 0, checks = 0, n_op = 0, n_oe = 0, cyc = 0, m, o;
    logic [7:0] rd [0:3];
    // Commands of the commit table
    logic [63:0] tw [0:7] = '{64'h0200012311000000, 64'h1200000234220000,
        64'h2012345600000000, 64'hd812345600000000, 64'h2101234567000000,
        64'hdc01234567000000, 64'h6000000000000000, 64'hc700000000000000};
    int tn [0:7] = '{5, 6, 4, 4, 5, 5, 1, 1};
    op_kind_t tk [0:7] = '{OP_PROGRAM, OP_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE,
        OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_CHIP_ERASE};
    logic [31:0] ta [0:5] = '{32'h00000123, 32'h00000234, 32'h00123000, 32'h00120000,
        32'h01234000, 32'h01230000};
    // Array contents: byte depends on address
    assign rd_byte_i = rd_addr_o[7:0] ^ 8'h5a;
    sf_front u_sf_front (.clk_i(clk_i), .rstn_i(rstn_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
        .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .dtr_i(dtr_i), .rd_addr_o(rd_addr_o),
        .rd_otp_o(rd_otp_o), .rd_active_o(rd_active_o), .rd_byte_i(rd_byte_i),
        .op_o(op_o), .op_done_i(op_done_i), .pg_idx_i(pg_idx_i), .pg_byte_o(pg_byte_o),
        .status_o(status_o));
    sf_host u_sf_host (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o),
        .so_oe_i(so_oe_o));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Record commits and driven output, cut a hang short
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (op_o.valid === 1'b1) begin
            last_op <= op_o;
            n_op <= n_op + 1;
        end
        if (so_oe_o === 1'b1) n_oe <= n_oe + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One frame: nb bytes sent from the top of w, then nr bytes read
    task automatic frame(input logic [63:0] w, input int nb, input int nr);
        logic [7:0] q;
        u_sf_host.start();
        for (int k = 0; k < nb; k++) u_sf_host.xfer(w[63-8*k -: 8], q);
        for (int k = 0; k < nr; k++) u_sf_host.xfer(8'h00, rd[k]);
        u_sf_host.stop();
    endtask
    task automatic cmd(input logic [7:0] b);
        frame({b, 56'h0}, 1, 0);
    endtask
    task automatic done();
        @(negedge clk_i) op_done_i = 1'b1;
        @(negedge clk_i) op_done_i = 1'b0;
    endtask
    initial begin
        {dtr_i, op_done_i, pg_idx_i, rstn_i} = '0;
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk(status_o, 32'h0);
        cmd(8'h06);
        chk(status_o.write_latch_flag, 32'h1);
        cmd(8'h04);
        chk(status_o.write_latch_flag, 32'h0);
        frame(tw[0], 5, 0);
        chk(n_op, 32'h0);
        for (int i = 0; i < 8; i++) begin
            cmd(8'h06);
            frame(tw[i], tn[i], 0);
            chk(n_op, i + 1);
            chk(last_op.kind, tk[i]);
            if (i < 6) chk(last_op.addr, ta[i]);
            if (i < 2) chk(last_op.count, 32'h1);
            chk(status_o.busy, 32'h1);
            done();
            chk(status_o.busy, 32'h0);
        end
        @(negedge clk_i) pg_idx_i = 8'h34;
        @(negedge clk_i);
        chk(pg_byte_o, 8'h22);
        cmd(8'h06);
        frame(tw[2], 4, 0);
        m = n_op;
        o = n_oe;
        frame(64'h0300001000000000, 4, 2);
        chk(n_oe, o);
        cmd(8'h06);
        frame(tw[4], 5, 0);
        chk(n_op, m);
        cmd(8'hb0);
        chk(status_o.suspended, 32'h1);
        cmd(8'h30);
        chk(status_o.suspended, 32'h0);
        done();
        frame(64'h0300001000000000, 4, 3);
        for (int k = 0; k < 3; k++) chk(rd[k], (8'h10 + k) ^ 8'h5a);
        frame(64'h0c00000020000000, 6, 2);
        for (int k = 0; k < 2; k++) chk(rd[k], (8'h20 + k) ^ 8'h5a);
        chk(so_oe_o, 32'h0);
        o = n_oe;
        frame(64'hff04000000000000, 2, 1);
        chk(status_o.write_latch_flag, 32'h1);
        chk(n_oe, o);
        chk(rd_active_o, 32'h0);
        frame(64'h2000000000000000, 3, 0);
        chk(n_op, m);
        frame(64'hc05a000000000000, 2, 0);
        chk(status_o.burst_len, 8'h5a);
        cmd(8'hb1);
        chk(status_o.secure, 32'h1);
        cmd(8'h06);
        frame(tw[2], 4, 0);
        chk(n_op, m);
        chk(rd_otp_o, 32'h1);
        frame(64'h0200000033000000, 5, 0);
        chk(last_op.otp, 32'h1);
        done();
        cmd(8'hc1);
        chk(status_o.secure, 32'h0);
        cmd(8'hb9);
        chk(status_o.deep_sleep, 32'h1);
        cmd(8'h06);
        chk(status_o.write_latch_flag, 32'h0);
        cmd(8'hfe);
        chk(status_o.deep_sleep, 32'h0);
        results();
    end
endmodule
